// ---- logic/slp_pkg.sv ----
package slp_pkg;
    // Timing of the transceiver as seen from the host
    localparam int unsigned CLK_HZ         = 25_000_000;
    localparam int unsigned INVALID_QUAL_US = 30;
    localparam int unsigned VALID_QUAL_US   = 1;
    localparam int unsigned RECOVER_US      = 100;
    localparam int unsigned WAKE_HOLD_CYC   = (RECOVER_US * (CLK_HZ / 1_000_000));
    localparam int unsigned QUAL_MARGIN_CYC = (VALID_QUAL_US * (CLK_HZ / 1_000_000));
    // Reset values and wake counter width
    localparam logic RST_SHUTDOWN_N = 1'b0;
    localparam logic RST_RX_DISABLE = 1'b1;
    localparam logic RST_UART_ON    = 1'b0;
    localparam int unsigned WAKE_CNT_W = 12;

    typedef enum logic [1:0] {
        SLP_MODE_OFF,
        SLP_MODE_AUTO,
        SLP_MODE_ON
    } slp_mode_t;
endpackage

// ---- logic/slp_host_ctrl.sv ----
// Function
// - Host drives receiver disable high whenever the UART is powered down.
// - Host drives shutdown request and hold awake to switch power modes.
// - Host powers the UART down on flag fall, up on flag rise.
`timescale 1ns/10ps
module slp_host_ctrl
    import slp_pkg::*;
#(
    parameter int unsigned WAKE_HOLD = WAKE_HOLD_CYC
) (
    input  wire logic            clk,
    input  wire logic            resetn,
    input  wire logic            clk_en,
    input  wire slp_pkg::slp_mode_t mode_sel,
    input  wire logic            line_valid,
    output logic                 shutdown_request_n,
    output logic                 hold_awake,
    output logic                 rx_disable,
    output logic                 uart_power_on,
    output logic                 tx_ready
);
    import slp_pkg::*;

    // ==========================================================
    // Pin synchroniser
    // ==========================================================
    logic valid_meta_ff;
    logic valid_sync_ff;
    logic valid_prev_ff;
    logic nxt_valid_meta;
    logic nxt_valid_sync;
    logic nxt_valid_prev;

    // The flag comes from the transceiver, so two stages before use
    always_comb begin
        nxt_valid_meta = line_valid;
        nxt_valid_sync = valid_meta_ff;
        nxt_valid_prev = valid_sync_ff;
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            valid_meta_ff <= 1'b0;
            valid_sync_ff <= 1'b0;
            valid_prev_ff <= 1'b0;
        end else if (clk_en) begin
            valid_meta_ff <= nxt_valid_meta;
            valid_sync_ff <= nxt_valid_sync;
            valid_prev_ff <= nxt_valid_prev;
        end
    end

    // ==========================================================
    // Device control pins
    // ==========================================================
    // Limitation: the host cannot see the device's true power state;
    // it infers it from the pins it drives and the synced flag only.
    logic shutdown_request_n_ff;
    logic hold_awake_ff;
    logic nxt_shutdown_request_n;
    logic nxt_hold_awake;

    // Decode the mode; code 3 is not legal and falls to automatic
    always_comb begin
        nxt_shutdown_request_n = 1'b1;
        nxt_hold_awake         = 1'b0;
        if (mode_sel == SLP_MODE_OFF) begin
            nxt_shutdown_request_n = 1'b0;
        end
        if (mode_sel == SLP_MODE_ON) begin
            nxt_hold_awake = 1'b1;
        end
    end

    // Pins come straight from flops so they never glitch at the device
    always_ff @(posedge clk) begin
        if (!resetn) begin
            shutdown_request_n_ff <= RST_SHUTDOWN_N;
            hold_awake_ff         <= 1'b0;
        end else if (clk_en) begin
            shutdown_request_n_ff <= nxt_shutdown_request_n;
            hold_awake_ff         <= nxt_hold_awake;
        end
    end

    // ==========================================================
    // UART power and receiver disable
    // ==========================================================
    logic rx_disable_ff;
    logic uart_on_ff;
    logic nxt_rx_disable;
    logic nxt_uart_on;
    logic flag_rise;
    logic flag_fall;

    // Edges come from the synced flag; prev resets low like the idle pin
    always_comb begin
        flag_rise = valid_sync_ff & ~valid_prev_ff;
        flag_fall = ~valid_sync_ff & valid_prev_ff;
        // Follow flag edges; flag valid in every mode
        nxt_uart_on = uart_on_ff;
        if (flag_rise) begin
            nxt_uart_on = 1'b1;
        end else if (flag_fall) begin
            nxt_uart_on = 1'b0;
        end
        // Receivers off while UART down
        // Disable in the same cycle as power-off so no current path through UART diodes
        nxt_rx_disable = ~nxt_uart_on | ~uart_on_ff;
    end

    // One cycle of extra disable on wake trades latency for safety
    always_ff @(posedge clk) begin
        if (!resetn) begin
            rx_disable_ff <= RST_RX_DISABLE;
            uart_on_ff    <= RST_UART_ON;
        end else if (clk_en) begin
            rx_disable_ff <= nxt_rx_disable;
            uart_on_ff    <= nxt_uart_on;
        end
    end

    // ==========================================================
    // Transmitter recovery timer
    // ==========================================================
    logic                  tx_ready_ff;
    logic [WAKE_CNT_W-1:0] wake_cnt_ff;
    logic                  nxt_tx_ready;
    logic [WAKE_CNT_W-1:0] nxt_wake_cnt;

    // Counter saturates at the limit, so a long wake cannot wrap it
    always_comb begin
        // In auto mode a low flag means the device sleeps
        nxt_wake_cnt = wake_cnt_ff;
        nxt_tx_ready = tx_ready_ff;
        if (nxt_shutdown_request_n == 1'b0
            || (nxt_hold_awake == 1'b0 && valid_sync_ff == 1'b0)) begin
            nxt_wake_cnt = '0;
            nxt_tx_ready = 1'b0;
        end else if (wake_cnt_ff >= WAKE_CNT_W'(WAKE_HOLD - 1)) begin
            nxt_tx_ready = 1'b1;
        end else begin
            nxt_wake_cnt = wake_cnt_ff + WAKE_CNT_W'(1);
        end
    end

    // Ready is conservative: typical recovery, never a guaranteed one
    always_ff @(posedge clk) begin
        if (!resetn) begin
            tx_ready_ff <= 1'b0;
            wake_cnt_ff <= '0;
        end else if (clk_en) begin
            tx_ready_ff <= nxt_tx_ready;
            wake_cnt_ff <= nxt_wake_cnt;
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================

    assign shutdown_request_n = shutdown_request_n_ff;
    assign hold_awake         = hold_awake_ff;
    assign rx_disable         = rx_disable_ff;
    assign uart_power_on      = uart_on_ff;
    assign tx_ready           = tx_ready_ff;
endmodule

// ---- test/slp_host_ctrl_assertions.sv ----
`timescale 1ns/10ps
// ==========
// Host-side pin and power checks
module slp_host_ctrl_assertions
    import slp_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic clk_en,
    input wire slp_pkg::slp_mode_t mode_sel,
    input wire logic line_valid,
    input wire logic shutdown_request_n,
    input wire logic hold_awake,
    input wire logic rx_disable,
    input wire logic uart_power_on
);
    default clocking dcb @(posedge clk); endclocking
    default disable iff (!resetn);
    uart_off_rx_a:
        assert property (!uart_power_on |-> rx_disable) else $error("rx on, uart off");
    rx_after_on_a:
        assert property ($rose(uart_power_on) |=> !rx_disable) else $error("rx late");
    off_pins_a:
        assert property (clk_en && mode_sel == SLP_MODE_OFF |=> !shutdown_request_n)
        else $error("off pin");
    on_pins_a:
        assert property (clk_en && mode_sel == SLP_MODE_ON |=> shutdown_request_n && hold_awake)
        else $error("on pins");
    flag_rise_a:
        assert property ($rose(line_valid) |-> ##[2:4] uart_power_on) else $error("uart up");
    flag_fall_a:
        assert property ($fell(line_valid) |-> ##[2:4] !uart_power_on) else $error("uart dn");
endmodule
bind slp_host_ctrl slp_host_ctrl_assertions chk_i (.clk(clk), .resetn(resetn),
    .clk_en(clk_en), .mode_sel(mode_sel), .line_valid(line_valid), .hold_awake(hold_awake),
    .shutdown_request_n(shutdown_request_n), .rx_disable(rx_disable),
    .uart_power_on(uart_power_on));

// ---- test/slp_dev_model.sv ----
`timescale 1ns/10ps
// ==========
// Transceiver model: flag qualification and power state
module slp_dev_model (
    input wire logic clk,
    input wire logic shutdown_request_n,
    input wire logic hold_awake,
    input wire logic line_active,
    output logic line_valid,
    output logic tx_on
);
    int cnt = 0;
    initial line_valid = 1'b0;
    // flag delays, 751 and 25 cycles
    // count restarts whenever line and flag agree
    always @(posedge clk) begin
        cnt <= (line_active != line_valid) ? cnt + 1 : 0;
        if (cnt == (line_active ? 24 : 750)) line_valid <= line_active;
    end
    // data path is outside this model
    assign tx_on = shutdown_request_n && (hold_awake || line_valid);
endmodule

// ---- test/serial_line_power_down_control_test.sv ----
`timescale 1ns/10ps
module serial_line_power_down_control_test;
    import slp_pkg::*;
    logic clk = 1'b0, resetn = 1'b0, clk_en = 1'b1, line_active = 1'b0, last = 1'b0;
    slp_mode_t mode_sel = SLP_MODE_AUTO;
    logic line_valid, shutdown_request_n, hold_awake, rx_disable, uart_power_on, tx_ready, tx_on;
    int mismatches = 0, samples_checked = 0;
    logic exp_q[$];
    always #20 clk = ~clk;
    slp_host_ctrl #(.WAKE_HOLD(8)) dut (.clk(clk), .resetn(resetn), .clk_en(clk_en),
        .mode_sel(mode_sel), .line_valid(line_valid), .hold_awake(hold_awake),
        .shutdown_request_n(shutdown_request_n), .rx_disable(rx_disable),
        .uart_power_on(uart_power_on), .tx_ready(tx_ready));
    slp_dev_model dev (.clk(clk), .shutdown_request_n(shutdown_request_n),
        .hold_awake(hold_awake), .line_active(line_active), .line_valid(line_valid),
        .tx_on(tx_on));
    task automatic step(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(string name, logic e, logic g);
        samples_checked++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] %s expected %b seen %b", name, e, g);
        end
    endtask
    task automatic conclude();
        $display("checked %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // Each UART power change takes the oldest expectation
    always @(negedge clk) if (resetn && uart_power_on !== last) begin
        last = uart_power_on;
        if (exp_q.size() == 0) chk("uart_power_on", ~uart_power_on, uart_power_on);
        else chk("uart_power_on", exp_q.pop_front(), uart_power_on);
    end
    initial begin
        logic [1:0] m;
        void'($urandom(17869));
        step(20);
        resetn = 1'b1;
        // Random modes, illegal code 3 acts as automatic
        for (int i = 0; i < 12; i++) begin
            m = 2'($urandom % 4);
            mode_sel = slp_mode_t'(m);
            step(2);
            chk("shutdown_request_n", m != 2'h0, shutdown_request_n);
            chk("hold_awake", m == 2'h2, hold_awake);
        end
        // Clock enable low must freeze the shutdown request pin
        clk_en = 1'b0;
        mode_sel = (m == 2'h0) ? SLP_MODE_ON : SLP_MODE_OFF;
        step(3);
        chk("shutdown_request_n", m != 2'h0, shutdown_request_n);
        clk_en = 1'b1;
        step(2);
        $display("mode test done");
        mode_sel = SLP_MODE_ON;
        line_active = 1'b1;
        exp_q.push_back(1'b1);
        step(60);
        chk("rx_disable", 1'b0, rx_disable);
        chk("tx_ready", 1'b1, tx_ready);
        line_active = 1'b0;
        exp_q.push_back(1'b0);
        step(800);
        chk("rx_disable", 1'b1, rx_disable);
        chk("tx_on", 1'b1, tx_on);
        chk("queue_empty", 1'b1, exp_q.size() == 0);
        $display("flag test done");
        mode_sel = SLP_MODE_AUTO;
        line_active = 1'b1;
        exp_q.push_back(1'b1);
        step(60);
        chk("tx_ready", 1'b1, tx_ready);
        chk("tx_on", 1'b1, tx_on);
        line_active = 1'b0;
        exp_q.push_back(1'b0);
        step(800);
        chk("tx_ready", 1'b0, tx_ready);
        chk("tx_on", 1'b0, tx_on);
        chk("queue_empty", 1'b1, exp_q.size() == 0);
        $display("auto test done");
        conclude();
    end
    // Run needs about 71us
    initial begin
        #200us;
        mismatches++;
        conclude();
    end
endmodule
